// ==== hdl/rsi_defines.svh ====
// constants for the robot safety interlock: offsets, fields, resets, timing
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RSI_OFF_CTRL 12'h000
`define RSI_OFF_STATUS 12'h004
`define RSI_OFF_IRQ_STAT 12'h008
`define RSI_OFF_IRQ_MASK 12'h00C
// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define RSI_CTRL_SERVO_REQ 0
`define RSI_CTRL_ALARM_RST 1
`define RSI_CTRL_START 2
`define RSI_CTRL_BRAKE_REQ 3
`define RSI_CTRL_RESET 4'h0
// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define RSI_ST_SERVO 0
`define RSI_ST_AUTO_RUN 1
`define RSI_ST_JOG_OK 2
`define RSI_ST_BRAKE_OK 3
`define RSI_ST_ERROR 4
`define RSI_ST_STOP 5
`define RSI_ST_DOOR_CLOSED 6
`define RSI_ST_ENABLE_CLOSED 7
// ----------------------------------------------------------------------
// interrupt event bits
// ----------------------------------------------------------------------
`define RSI_EV_DOOR_ERR 0
`define RSI_EV_STOP_EDGE 1
`define RSI_EV_SERVO_CUT 2
`define RSI_EV_CH_MISMATCH 3
`define RSI_EV_RESET 4'h0
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RSI_CLK_MHZ 125
`define RSI_STOP_RESP_US 1
`define RSI_STOP_FILT_CYC 2
`endif

// ==== hdl/rsi_pkg.sv ====
// types shared by the robot safety interlock
package rsi_pkg;
  // dual-channel contact pair, both closed means safe
  typedef struct packed {
    logic chA;
    logic chB;
  } rsi_pair_s;

  // operator inputs from the pendant and controller
  typedef struct packed {
    logic pendantEnabled;
    logic enableSwitch;
    logic manualMode;
  } rsi_pendant_s;

  // permissions presented to the motion side
  typedef struct packed {
    logic servoOn;
    logic autoRun;
    logic jogOk;
    logic brakeOk;
    logic stopCmd;
    logic error;
  } rsi_perm_s;

  typedef enum logic [1:0] {
    RSI_IDLE,
    RSI_SERVO,
    RSI_RUN,
    RSI_FAULT
  } rsi_state_e;
endpackage

// ==== hdl/rsi_dual_input.sv ====
// dual-channel normally closed contact reader with channel agreement
`timescale 1ns/1ps
`default_nettype none
module rsi_dual_input
  import rsi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire rsi_pair_s contact,
  output logic closed,
  output logic mismatch
);
  // ----------------------------------------------------------------------
  // registered reading
  // ----------------------------------------------------------------------
  // either channel open, or the two disagreeing, reads as open
  always_ff @(posedge clk) begin
    if (reset) begin
      closed <= 1'b0;
      mismatch <= 1'b0;
    end else begin
      closed <= contact.chA & contact.chB;
      mismatch <= contact.chA ^ contact.chB;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/rsi_interlock.sv ====
// robot safety interlock: servo, jog, brake and automatic run permissions
//
// Notes on behaviour
// - special stop input commands robot stop
// - stop input change seen within one microsecond
// - door open in auto: servo off, error
// - teaching allows servo and jog, door open
// - door open: servo needs both switches held
// - door open: enabling release cuts servo
// - enabling released refuses servo and brake (code: servo still allowed with door closed)
// - door closed: pendant alone turns servo on
// - manual jog with enabling closed, any door
// - enabling open: jog only with door closed
// - brake release manual, pendant, enabling closed
// - automatic only with pendant off, door closed
// - door and enabling are dual NC contacts
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rsi_defines.svh"
module rsi_interlock
  import rsi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic stopIn,
  input wire rsi_pair_s doorContact,
  input wire rsi_pair_s enableContact,
  input wire rsi_pendant_s pendant,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rsi_perm_s perm,
  output logic irq
);
  // ----------------------------------------------------------------------
  // local declarations
  // ----------------------------------------------------------------------
  localparam int StopCyc = `RSI_STOP_FILT_CYC;
  logic doorClosed;
  logic doorMis;
  logic enClosed;
  logic enMis;
  logic stopSeen_q;
  logic stopPrev_q;
  logic [3:0] ctrl_q;
  logic [3:0] evStat_q;
  logic [3:0] evMask_q;
  logic [3:0] evSet;
  rsi_state_e state_q;
  rsi_state_e state_d;
  logic servoAllowed;
  logic jogAllowed;
  logic brakeAllowed;
  logic autoAllowed;
  logic servoCut;
  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic [31:0] rdData;

  // ----------------------------------------------------------------------
  // contact readers
  // ----------------------------------------------------------------------
  rsi_dual_input u_door (
    .clk(clk),
    .reset(reset),
    .contact(doorContact),
    .closed(doorClosed),
    .mismatch(doorMis)
  );

  rsi_dual_input u_enable (
    .clk(clk),
    .reset(reset),
    .contact(enableContact),
    .closed(enClosed),
    .mismatch(enMis)
  );

  // ----------------------------------------------------------------------
  // special stop input
  // ----------------------------------------------------------------------
  // input and output registers: 16 ns latency to perm.stopCmd, far inside the 1 us budget
  always_ff @(posedge clk) begin
    if (reset) begin
      stopSeen_q <= 1'b0;
      stopPrev_q <= 1'b0;
    end else begin
      stopSeen_q <= stopIn;
      stopPrev_q <= stopSeen_q;
    end
  end

  // ----------------------------------------------------------------------
  // permission logic
  // ----------------------------------------------------------------------
  // helper shared by jog and brake: manual, pendant live, switch held
  function automatic logic manualReady(input rsi_pendant_s p);
    manualReady = p.manualMode & p.pendantEnabled & p.enableSwitch;
  endfunction

  always_comb begin
    // door closed: pendant alone suffices
    // door open: enabling device must also be held
    if (pendant.manualMode) begin
      servoAllowed = pendant.pendantEnabled & pendant.enableSwitch
                     & (doorClosed | enClosed);
    end else begin
      servoAllowed = ~pendant.pendantEnabled & doorClosed;
    end
    // enabling closed: any door; enabling open: door closed
    jogAllowed = manualReady(pendant) & (enClosed | doorClosed);
    // brake release ignores door entirely
    brakeAllowed = manualReady(pendant) & enClosed;
    autoAllowed = ~pendant.manualMode & ~pendant.pendantEnabled & doorClosed;
  end

  // ----------------------------------------------------------------------
  // servo state machine
  // ----------------------------------------------------------------------
  // servo request is level; start and alarm reset are pulses from writes
  always_comb begin
    state_d = state_q;
    servoCut = 1'b0;
    case (state_q)
      RSI_IDLE: begin
        if (ctrl_q[`RSI_CTRL_SERVO_REQ] & servoAllowed & ~stopSeen_q) begin
          state_d = RSI_SERVO;
        end
      end
      RSI_SERVO: begin
        if (~servoAllowed | ~ctrl_q[`RSI_CTRL_SERVO_REQ]) begin
          state_d = RSI_IDLE;
          servoCut = ~servoAllowed;
        end else if (ctrl_q[`RSI_CTRL_START] & autoAllowed & ~stopSeen_q) begin
          state_d = RSI_RUN;
        end
      end
      RSI_RUN: begin
        // door opening in auto removes servo and raises error
        if (~doorClosed) begin
          state_d = RSI_FAULT;
          servoCut = 1'b1;
        end else if (~autoAllowed | ~ctrl_q[`RSI_CTRL_SERVO_REQ]) begin
          state_d = RSI_IDLE;
          servoCut = ~autoAllowed;
        end else if (stopSeen_q) begin
          state_d = RSI_SERVO;
        end
      end
      RSI_FAULT: begin
        // alarm reset accepted only once the door is closed again
        if (ctrl_q[`RSI_CTRL_ALARM_RST] & doorClosed) begin
          state_d = RSI_IDLE;
        end
      end
      default: begin
        state_d = RSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= RSI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // permission outputs
  // ----------------------------------------------------------------------
  // registered so the motion side sees glitch-free levels
  always_ff @(posedge clk) begin
    if (reset) begin
      perm <= '0;
    end else begin
      perm.servoOn <= (state_d == RSI_SERVO) | (state_d == RSI_RUN);
      perm.autoRun <= (state_d == RSI_RUN) & ~stopSeen_q;
      perm.jogOk <= jogAllowed & (state_d == RSI_SERVO) & ~stopSeen_q;
      perm.brakeOk <= brakeAllowed & ctrl_q[`RSI_CTRL_BRAKE_REQ];
      perm.stopCmd <= stopSeen_q;
      perm.error <= (state_d == RSI_FAULT);
    end
  end

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `RSI_OFF_CTRL) | (a == `RSI_OFF_STATUS)
               | (a == `RSI_OFF_IRQ_STAT) | (a == `RSI_OFF_IRQ_MASK);
  endfunction

  assign addrOk = isMapped(paddr);
  assign pslverr = psel & penable & ~addrOk;

  // control: servo and brake requests are levels, start and reset self-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `RSI_CTRL_RESET;
    end else if (wrEn & (paddr == `RSI_OFF_CTRL)) begin
      ctrl_q <= pwdata[3:0];
    end else begin
      ctrl_q[`RSI_CTRL_START] <= 1'b0;
      ctrl_q[`RSI_CTRL_ALARM_RST] <= 1'b0;
    end
  end

  // events: set wins over a write-one clear in the same cycle
  always_comb begin
    evSet = '0;
    evSet[`RSI_EV_DOOR_ERR] = (state_q == RSI_RUN) & (state_d == RSI_FAULT);
    evSet[`RSI_EV_STOP_EDGE] = stopSeen_q ^ stopPrev_q;
    evSet[`RSI_EV_SERVO_CUT] = servoCut;
    evSet[`RSI_EV_CH_MISMATCH] = doorMis | enMis;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evStat_q <= `RSI_EV_RESET;
    end else if (wrEn & (paddr == `RSI_OFF_IRQ_STAT)) begin
      evStat_q <= (evStat_q & ~pwdata[3:0]) | evSet;
    end else begin
      evStat_q <= evStat_q | evSet;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evMask_q <= `RSI_EV_RESET;
    end else if (wrEn & (paddr == `RSI_OFF_IRQ_MASK)) begin
      evMask_q <= pwdata[3:0];
    end
  end

  // level interrupt while any unmasked event is pending
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evStat_q & evMask_q);
    end
  end

  // read mux; unmapped addresses read zero with an error answer
  always_comb begin
    rdData = '0;
    case (paddr)
      `RSI_OFF_CTRL: rdData[3:0] = ctrl_q;
      `RSI_OFF_STATUS: begin
        rdData[`RSI_ST_SERVO] = perm.servoOn;
        rdData[`RSI_ST_AUTO_RUN] = perm.autoRun;
        rdData[`RSI_ST_JOG_OK] = perm.jogOk;
        rdData[`RSI_ST_BRAKE_OK] = perm.brakeOk;
        rdData[`RSI_ST_ERROR] = perm.error;
        rdData[`RSI_ST_STOP] = perm.stopCmd;
        rdData[`RSI_ST_DOOR_CLOSED] = doorClosed;
        rdData[`RSI_ST_ENABLE_CLOSED] = enClosed;
      end
      `RSI_OFF_IRQ_STAT: rdData[3:0] = evStat_q;
      `RSI_OFF_IRQ_MASK: rdData[3:0] = evMask_q;
      default: rdData = '0;
    endcase
  end

  // read data registered on the setup cycle so it is ready in access
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdData;
    end
  end

  // keep the filter constant referenced for timing review
  logic unusedStopCyc;
  assign unusedStopCyc = (StopCyc > 0) & rdEn;
endmodule
`default_nettype wire

// ==== tb/rsi_interlock_sva.sv ====
// assertion checker for the robot safety interlock ports
`timescale 1ns/1ps
`default_nettype none
module rsi_interlock_sva
  import rsi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic stopIn,
  input wire rsi_pair_s doorContact,
  input wire rsi_pair_s enableContact,
  input wire rsi_pendant_s pendant,
  input wire rsi_perm_s perm
);
  logic [1:0] warm_q;
  logic doorOk;
  logic enOk;
  logic tchOk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // $past reaches back two edges, so no $past check is judged before three clean edges
  always_ff @(posedge clk) begin
    if (reset) begin
      warm_q <= 2'h0;
    end else if (warm_q != 2'h3) begin
      warm_q <= warm_q + 2'h1;
    end
  end
  // a pair only counts as closed when both channels agree
  assign doorOk = doorContact.chA & doorContact.chB;
  assign enOk = enableContact.chA & enableContact.chB;
  assign tchOk = pendant.manualMode & pendant.pendantEnabled & pendant.enableSwitch;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_stop_cmd_follow: assert property (warm_q == 2'h3 |-> perm.stopCmd == $past(stopIn, 2))
    else $error("stop command does not follow the stop input");
  a_servo_both_open: assert property (
    warm_q == 2'h3 && !$past(doorOk, 2) && !$past(enOk, 2) |-> !perm.servoOn)
    else $error("servo on with door and enabling both open");
  a_brake_needs_en: assert property (warm_q == 2'h3 && !$past(enOk, 2) |-> !perm.brakeOk)
    else $error("brake release with enabling open");
  a_brake_manual_only: assert property (
    warm_q == 2'h3 && perm.brakeOk |-> $past(tchOk, 1) || $past(tchOk, 2))
    else $error("brake release outside manual teaching");
  a_jog_conditions: assert property (
    warm_q == 2'h3 && perm.jogOk |-> $past(enOk, 2) || $past(doorOk, 2))
    else $error("jog allowed with enabling and door open");
  a_auto_door_pendant: assert property (
    warm_q == 2'h3 && perm.autoRun |->
      $past(doorOk, 2) && !($past(pendant.pendantEnabled, 1) && $past(pendant.pendantEnabled, 2)))
    else $error("automatic run without closed door or with pendant on");
  a_door_fault_stop: assert property (
    perm.autoRun && !doorOk && !stopIn |-> ##[1:4] (perm.error && !perm.servoOn && !perm.autoRun))
    else $error("door opening in automatic run not faulted");
  a_error_no_servo: assert property (perm.error |-> !perm.servoOn && !perm.autoRun)
    else $error("servo or run present during error");
endmodule
bind rsi_interlock rsi_interlock_sva u_rsi_interlock_sva (
  .clk(clk),
  .reset(reset),
  .stopIn(stopIn),
  .doorContact(doorContact),
  .enableContact(enableContact),
  .pendant(pendant),
  .perm(perm)
);
`default_nettype wire

// ==== tb/rsi_switch_model.sv ====
// dual-channel fence door and enabling device contacts
`timescale 1ns/1ps
`default_nettype none
module rsi_switch_model
  import rsi_pkg::*;
(
  input wire logic clk,
  input wire logic doorWant,
  input wire logic enWant,
  input wire logic [1:0] breakCh,
  output rsi_pair_s doorContact,
  output rsi_pair_s enableContact
);
  // normally closed: 1 = closed; channel B lags A a clock, a broken B reads open
  initial begin
    doorContact = 2'h0;
    enableContact = 2'h0;
  end
  always @(posedge clk) begin
    doorContact.chA <= doorWant;
    doorContact.chB <= doorContact.chA & ~breakCh[0];
    enableContact.chA <= enWant;
    enableContact.chB <= enableContact.chA & ~breakCh[1];
  end
endmodule
`default_nettype wire

// ==== tb/rsi_interlock_bench.sv ====
// self-checking bench for the robot safety interlock
`timescale 1ns/1ps
`default_nettype none
`include "rsi_defines.svh"
module rsi_interlock_bench
  import rsi_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, stopIn = 1'b0, doorWant = 1'b1, enWant = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] breakCh = 2'h0;
  rsi_pendant_s pendant = 3'h0;
  rsi_pair_s doorContact, enableContact;
  rsi_perm_s perm;
  int num_errors = 0, n_compared = 0;
  rsi_interlock u_rsi_interlock (.clk(clk), .reset(reset), .stopIn(stopIn),
    .doorContact(doorContact), .enableContact(enableContact), .pendant(pendant),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .perm(perm), .irq(irq));
  rsi_switch_model u_rsi_switch_model (.clk(clk), .doorWant(doorWant), .enWant(enWant),
    .breakCh(breakCh), .doorContact(doorContact), .enableContact(enableContact));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer; the bound on pready only cuts a hang short
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    // a lost answer is a failure, not a quiet end of the run
    if (n == 50) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    chk("pslverr", pslverr, a > `RSI_OFF_IRQ_MASK);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // contacts lag up to two clocks in the model, then two edges in the block
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  function automatic logic expServo(rsi_pendant_s p, logic d, logic e);
    if (p.manualMode) return p.pendantEnabled & p.enableSwitch & (d | e);
    return ~p.pendantEnabled & d;
  endfunction
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rd = $urandom(92);
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, `RSI_OFF_IRQ_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", rd, 32'h0);
    // teaching, door closed, enabling open: pendant alone
    pendant <= 3'h7;
    apb(1'b1, `RSI_OFF_CTRL, 32'h9);
    settle();
    chk("servo door closed", perm.servoOn, 1'b1);
    chk("jog door closed", perm.jogOk, 1'b1);
    chk("brake en open", perm.brakeOk, 1'b0);
    // status word: servo, jog and door closed set, enabling reads open
    apb(1'b0, `RSI_OFF_STATUS, 32'h0);
    chk("status teach", rd, 32'h45);
    doorWant <= 1'b0;
    settle();
    chk("servo both open", perm.servoOn, 1'b0);
    chk("jog both open", perm.jogOk, 1'b0);
    enWant <= 1'b1;
    settle();
    chk("servo door open", perm.servoOn, 1'b1);
    chk("jog en closed", perm.jogOk, 1'b1);
    chk("brake en closed", perm.brakeOk, 1'b1);
    breakCh <= 2'h2;
    settle();
    chk("servo mismatch", perm.servoOn, 1'b0);
    // clear first: the lagging channel also flags on every clean change,
    // so only a flag that comes back proves the broken channel is seen
    apb(1'b1, `RSI_OFF_IRQ_STAT, 32'hF);
    apb(1'b0, `RSI_OFF_IRQ_STAT, 32'h0);
    chk("mismatch event", rd & 32'h8, 32'h8);
    breakCh <= 2'h0;
    settle();
    enWant <= 1'b0;
    settle();
    chk("servo en released", perm.servoOn, 1'b0);
    chk("brake en released", perm.brakeOk, 1'b0);
    // automatic run, stop, door fault and recovery
    doorWant <= 1'b1;
    pendant <= 3'h0;
    apb(1'b1, `RSI_OFF_IRQ_STAT, 32'hF);
    apb(1'b1, `RSI_OFF_IRQ_MASK, 32'h1);
    apb(1'b1, `RSI_OFF_CTRL, 32'h1);
    settle();
    apb(1'b1, `RSI_OFF_CTRL, 32'h5);
    settle();
    chk("auto run", perm.autoRun, 1'b1);
    stopIn <= 1'b1;
    settle();
    chk("stop command", perm.stopCmd, 1'b1);
    stopIn <= 1'b0;
    settle();
    apb(1'b1, `RSI_OFF_CTRL, 32'h5);
    settle();
    doorWant <= 1'b0;
    settle();
    chk("door fault", {perm.error, perm.servoOn, perm.autoRun, irq}, 4'h9);
    doorWant <= 1'b1;
    apb(1'b1, `RSI_OFF_CTRL, 32'h5);
    settle();
    chk("start before alarm reset", perm.autoRun, 1'b0);
    apb(1'b1, `RSI_OFF_CTRL, 32'h2);
    apb(1'b1, `RSI_OFF_IRQ_STAT, 32'hF);
    settle();
    chk("alarm cleared", {perm.error, irq}, 2'h0);
    apb(1'b1, `RSI_OFF_CTRL, 32'h1);
    settle();
    apb(1'b1, `RSI_OFF_CTRL, 32'h5);
    settle();
    chk("restart", perm.autoRun, 1'b1);
    stopIn <= 1'b1;
    settle();
    stopIn <= 1'b0;
    apb(1'b1, `RSI_OFF_CTRL, 32'h9);
    // random switch states with servo and brake requested
    repeat (40) begin
      pendant <= 3'($urandom);
      doorWant <= 1'($urandom);
      enWant <= 1'($urandom);
      settle();
      chk("servo random", perm.servoOn, expServo(pendant, doorWant, enWant));
      chk("jog random", perm.jogOk, pendant.manualMode & expServo(pendant, doorWant, enWant));
      chk("brake random", perm.brakeOk, (&pendant) & enWant);
    end
    end_sim();
  end
endmodule
`default_nettype wire
